// file: core/user_flash_regs.svh
// timing counts and field sizes for the user flash serial port
`ifndef USER_FLASH_REGS_SVH
`define USER_FLASH_REGS_SVH

`define UF_ADDR_W          9
`define UF_DATA_W          16
`define UF_WORDS           512
`define UF_SECTOR_BIT      8
`define UF_ADDR_LAST       9'h1ff
`define UF_SEC0_LAST       9'h0ff
`define UF_SEC1_FIRST      9'h100
`define UF_ERASED_WORD     16'hffff
`define UF_CLK_MHZ         40
`define UF_OSC_TICK_NS     50
`define UF_OSC_TICK_CYC    ((`UF_OSC_TICK_NS * `UF_CLK_MHZ + 999) / 1000)
`define UF_OSC_DIV         4
`define UF_PROG_OSC_TICKS  16
`define UF_ERASE_OSC_TICKS 64
`define UF_BUSY_LAG_TICKS  2

`endif

// file: core/user_flash_pkg.sv
// types shared by both ends of the user flash serial port
package user_flash_pkg;
    typedef enum logic [1:0] {
        CMD_NONE,
        CMD_PROGRAM,
        CMD_ERASE
    } flash_cmd_t;
endpackage

// file: core/user_flash_if.sv
// serial link between the user flash block and fabric user logic
`timescale 1ns/100ps
`default_nettype none
interface user_flash_if;
    logic address_shift_control;
    logic address_shift_clock;
    logic address_serial_in;
    logic data_shift_control;
    logic data_shift_clock;
    logic data_serial_in;
    logic data_serial_out;
    logic program_req;
    logic erase_req;
    logic busy;
    logic divided_internal_clock_out;

    modport flash (
        input  address_shift_control, address_shift_clock, address_serial_in,
        input  data_shift_control, data_shift_clock, data_serial_in,
        input  program_req, erase_req,
        output data_serial_out, busy, divided_internal_clock_out
    );
    modport user (
        output address_shift_control, address_shift_clock, address_serial_in,
        output data_shift_control, data_shift_clock, data_serial_in,
        output program_req, erase_req,
        input  data_serial_out, busy, divided_internal_clock_out
    );
endinterface
`default_nettype wire

// file: core/user_flash_array.sv
// user flash block: 512x16 array, serial shift ports, self-timed program/erase
`include "user_flash_regs.svh"
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - 512 words at addresses 000h to 1ffh
// - two sectors split at address 100h
// - each stored word is 16 bits
// - erase sets one whole sector only
// - user erases a sector before programming it
// - block runs program or erase by itself
// - user holds request until busy falls
// - internal oscillator times program and erase from the serial link
// - oscillator divided by four drives out
// - output frequency fixed, no setting changes it
// - single reads and stream reads both supported
// - shift control low plus clock increments address
// - address shifter 9 bits, data shifter 16
// - jtag path can also read and program
module user_flash_array
    import user_flash_pkg::*;
#(
    parameter int OSC_TICK_CYC = `UF_OSC_TICK_CYC,
    parameter int PROG_TICKS   = `UF_PROG_OSC_TICKS,
    parameter int ERASE_TICKS  = `UF_ERASE_OSC_TICKS
) (
    input  wire logic                  i_ref_clk,       // 40 mhz clock
    input  wire logic                  i_nrst,          // sync reset, low
    user_flash_if.flash                link,            // fabric side
    input  wire logic                  i_jtag_en,       // jtag owns the array
    input  wire logic [`UF_ADDR_W-1:0] i_jtag_addr,     // jtag word address
    input  wire logic [`UF_DATA_W-1:0] i_jtag_wdata,    // jtag program data
    input  wire logic                  i_jtag_prog,     // jtag program pulse
    output logic      [`UF_DATA_W-1:0] o_jtag_rdata     // jtag read data
);
    logic [`UF_DATA_W-1:0] mem [`UF_WORDS];

    // synchronisers: link signals come from another timing domain
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [7:0] sync_in;
    assign sync_in = {link.address_shift_control, link.address_shift_clock,
                      link.address_serial_in, link.data_shift_control,
                      link.data_shift_clock, link.data_serial_in,
                      link.program_req, link.erase_req};
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
        end else begin
            sync1_reg <= sync_in;
            sync2_reg <= sync1_reg;
        end
    end
    logic ashift, aclk, adin, dshift, dclk, ddin, prog_rq, erase_rq;
    assign {ashift, aclk, adin, dshift, dclk, ddin, prog_rq, erase_rq} = sync2_reg;

    logic aclk_d_reg, dclk_d_reg;
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            aclk_d_reg <= 1'b0;
            dclk_d_reg <= 1'b0;
        end else begin
            aclk_d_reg <= aclk;
            dclk_d_reg <= dclk;
        end
    end
    logic aclk_rise, dclk_rise;
    assign aclk_rise = aclk & ~aclk_d_reg;
    assign dclk_rise = dclk & ~dclk_d_reg;

    // oscillator: fixed tick divider, no setting alters it
    logic [7:0] tick_cnt_reg;
    logic       osc_tick;
    assign osc_tick = (tick_cnt_reg == 8'(OSC_TICK_CYC - 1));
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            tick_cnt_reg <= 8'h00;
        end else if (osc_tick) begin
            tick_cnt_reg <= 8'h00;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 8'h01;
        end
    end

    logic [1:0] osc_div_reg;
    logic       osc_out_reg;
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            osc_div_reg <= 2'h0;
            osc_out_reg <= 1'b0;
        end else if (osc_tick) begin
            osc_div_reg <= osc_div_reg + 2'h1;
            if (osc_div_reg[0])
                osc_out_reg <= ~osc_out_reg;           // osc / 4
        end
    end
    assign link.divided_internal_clock_out = osc_out_reg;

    // address shifter
    logic [`UF_ADDR_W-1:0] addr_reg;
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            addr_reg <= '0;
        end else if (aclk_rise && ashift) begin
            addr_reg <= {addr_reg[`UF_ADDR_W-2:0], adin};
        end else if (aclk_rise) begin
            addr_reg <= addr_reg + 9'h001;                // wraps at 1ffh
        end
    end

    // sequencer
    typedef enum logic [1:0] {S_IDLE, S_RUN, S_DONE} seq_t;
    seq_t                  state_reg;
    flash_cmd_t            cmd_reg;
    logic [7:0]            run_cnt_reg;
    logic                  busy_reg;
    logic [`UF_ADDR_W-1:0] op_addr_reg;
    logic [`UF_DATA_W-1:0] op_data_reg;
    logic [`UF_DATA_W-1:0] data_reg;

    function automatic logic in_sector(input logic [`UF_ADDR_W-1:0] a,
                                       input logic [`UF_ADDR_W-1:0] b);
        in_sector = (a[`UF_SECTOR_BIT] == b[`UF_SECTOR_BIT]);
    endfunction

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            state_reg   <= S_IDLE;
            cmd_reg     <= CMD_NONE;
            run_cnt_reg <= 8'h00;
            busy_reg    <= 1'b0;
            op_addr_reg <= '0;
            op_data_reg <= '0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if ((prog_rq || erase_rq) && !i_jtag_en) begin
                        cmd_reg     <= erase_rq ? CMD_ERASE : CMD_PROGRAM;
                        op_addr_reg <= addr_reg;
                        op_data_reg <= data_reg;
                        run_cnt_reg <= 8'h00;
                        busy_reg    <= 1'b1;
                        state_reg   <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (osc_tick) begin
                        run_cnt_reg <= run_cnt_reg + 8'h01;
                        if (run_cnt_reg == 8'((cmd_reg == CMD_ERASE) ? ERASE_TICKS - 1
                                                                   : PROG_TICKS - 1))
                            state_reg <= S_DONE;
                    end
                end
                S_DONE: begin
                    busy_reg <= 1'b0;
                    // wait for release so a held request is not rerun
                    if (!prog_rq && !erase_rq)
                        state_reg <= S_IDLE;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
    assign link.busy = busy_reg;

    // array writes; programming can only clear bits, erase sets a sector
    always_ff @(posedge i_ref_clk) begin
        if (state_reg == S_RUN && osc_tick && run_cnt_reg == 8'h00) begin
            for (int i = 0; i < `UF_WORDS; i++) begin
                if (cmd_reg == CMD_ERASE && in_sector(9'(i), op_addr_reg))
                    mem[i] <= `UF_ERASED_WORD;
            end
            if (cmd_reg == CMD_PROGRAM)
                mem[op_addr_reg] <= mem[op_addr_reg] & op_data_reg;
        end else if (i_jtag_en && i_jtag_prog && state_reg == S_IDLE) begin
            mem[i_jtag_addr] <= mem[i_jtag_addr] & i_jtag_wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst)
            o_jtag_rdata <= '0;
        else
            o_jtag_rdata <= mem[i_jtag_addr];
    end

    // data shifter: control high shifts in, low loads then shifts out
    logic dshift_d_reg;
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            data_reg     <= '0;
            dshift_d_reg <= 1'b0;
        end else begin
            dshift_d_reg <= dshift;
            if (dclk_rise && dshift)
                data_reg <= {data_reg[`UF_DATA_W-2:0], ddin};
            else if (dclk_rise)
                data_reg <= {data_reg[`UF_DATA_W-2:0], 1'b0};
            else if (aclk_rise && !ashift)
                data_reg <= mem[addr_reg + 9'h001];
            else if (!dshift && dshift_d_reg)
                data_reg <= mem[addr_reg];
        end
    end
    assign link.data_serial_out = data_reg[`UF_DATA_W-1];
endmodule
`default_nettype wire

// file: core/user_flash_user.sv
// fabric user logic end: parallel commands to the serial flash link
`include "user_flash_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module user_flash_user
    import user_flash_pkg::*;
(
    input  wire logic                  i_ref_clk,   // 40 mhz clock
    input  wire logic                  i_nrst,      // sync reset, low
    user_flash_if.user                 link,        // flash side
    input  wire logic                  i_start,     // one-cycle command strobe
    input  wire flash_cmd_t            i_cmd,       // none=read, program, erase
    input  wire logic [`UF_ADDR_W-1:0] i_addr,      // word address
    input  wire logic [`UF_DATA_W-1:0] i_wdata,     // program data
    input  wire logic                  i_next,      // stream read next word
    output logic                       o_ready,     // idle, accepts i_start/i_next
    output logic      [`UF_DATA_W-1:0] o_rdata,     // read word
    output logic                       o_rvalid,    // read word pulse
    output logic                       o_done       // program/erase done pulse
);
    typedef enum logic [2:0] {U_IDLE, U_ADDR, U_DATA, U_LOAD, U_READ, U_REQ, U_WAIT} ustate_t;
    ustate_t               st_reg;
    flash_cmd_t            cmd_reg;
    logic [`UF_ADDR_W-1:0] a_reg;
    logic [`UF_DATA_W-1:0] d_reg;
    logic [4:0]            bit_reg;
    logic                  ph_reg;
    logic                  aclk_reg, ashift_reg, adin_reg;
    logic                  dclk_reg, dshift_reg, ddin_reg;
    logic                  preq_reg, ereq_reg;
    logic [1:0]            busy_s_reg;
    logic [7:0]            hold_reg;
    logic                  bsync1_reg;
    logic [1:0]            dout_s_reg;

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            bsync1_reg <= 1'b0;
            busy_s_reg <= 2'b00;
            dout_s_reg <= 2'b00;
        end else begin
            bsync1_reg <= link.busy;
            busy_s_reg <= {busy_s_reg[0], bsync1_reg};
            dout_s_reg <= {dout_s_reg[0], link.data_serial_out};
        end
    end

    // each serial phase lasts 8 cycles to outrun the flash's synchronisers
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            st_reg <= U_IDLE; cmd_reg <= CMD_NONE; a_reg <= '0; d_reg <= '0;
            bit_reg <= 5'h00; ph_reg <= 1'b0; hold_reg <= 8'h00;
            aclk_reg <= 1'b0; ashift_reg <= 1'b0; adin_reg <= 1'b0;
            dclk_reg <= 1'b0; dshift_reg <= 1'b0; ddin_reg <= 1'b0;
            preq_reg <= 1'b0; ereq_reg <= 1'b0;
            o_ready <= 1'b0; o_rdata <= '0; o_rvalid <= 1'b0; o_done <= 1'b0;
        end else begin
            o_rvalid <= 1'b0;
            o_done   <= 1'b0;
            hold_reg <= hold_reg + 8'h01;
            case (st_reg)
                U_IDLE: begin
                    o_ready <= 1'b1;
                    if (i_start) begin
                        o_ready <= 1'b0; cmd_reg <= i_cmd; a_reg <= i_addr;
                        d_reg <= i_wdata; bit_reg <= 5'h00; hold_reg <= 8'h00;
                        ph_reg <= 1'b0; ashift_reg <= 1'b1; st_reg <= U_ADDR;
                    end else if (i_next) begin
                        o_ready <= 1'b0; ashift_reg <= 1'b0; aclk_reg <= 1'b1;
                        hold_reg <= 8'h00; bit_reg <= 5'h00; st_reg <= U_READ;
                        ph_reg <= 1'b0;
                    end
                end
                U_ADDR: if (hold_reg == 8'h07) begin            // msb first
                    hold_reg <= 8'h00;
                    ph_reg   <= ~ph_reg;
                    if (!ph_reg) begin
                        adin_reg <= a_reg[`UF_ADDR_W-1];
                        aclk_reg <= 1'b0;
                    end else begin
                        aclk_reg <= 1'b1;
                        a_reg    <= {a_reg[`UF_ADDR_W-2:0], 1'b0};
                        bit_reg  <= bit_reg + 5'h01;
                        if (bit_reg == 5'(`UF_ADDR_W - 1)) begin
                            bit_reg <= 5'h00;
                            st_reg  <= (cmd_reg == CMD_PROGRAM) ? U_DATA : U_LOAD;
                            // raised for every command; its fall loads a read word
                            dshift_reg <= 1'b1;
                        end
                    end
                end
                U_DATA: if (hold_reg == 8'h07) begin
                    hold_reg <= 8'h00;
                    ph_reg   <= ~ph_reg;
                    if (!ph_reg) begin
                        ddin_reg <= d_reg[`UF_DATA_W-1]; dclk_reg <= 1'b0;
                    end else begin
                        dclk_reg <= 1'b1; d_reg <= {d_reg[`UF_DATA_W-2:0], 1'b0};
                        bit_reg  <= bit_reg + 5'h01;
                        if (bit_reg == 5'(`UF_DATA_W - 1)) begin
                            // control stays high: a fall would reload the shifter
                            st_reg <= U_REQ;
                        end
                    end
                end
                U_LOAD: if (hold_reg == 8'h07) begin
                    hold_reg <= 8'h00; aclk_reg <= 1'b0; dshift_reg <= 1'b0;
                    ashift_reg <= 1'b0;                          // settled before a stream clock
                    st_reg <= (cmd_reg == CMD_ERASE) ? U_REQ : U_READ;
                end
                U_READ: if (hold_reg == 8'h07) begin
                    hold_reg <= 8'h00;
                    ph_reg   <= ~ph_reg;
                    aclk_reg <= 1'b0;
                    if (!ph_reg) begin
                        d_reg    <= {d_reg[`UF_DATA_W-2:0], dout_s_reg[1]};
                        dclk_reg <= 1'b0;
                        bit_reg  <= bit_reg + 5'h01;
                        if (bit_reg == 5'(`UF_DATA_W - 1)) begin
                            o_rdata  <= {d_reg[`UF_DATA_W-2:0], dout_s_reg[1]};
                            o_rvalid <= 1'b1; st_reg <= U_IDLE;
                        end
                    end else begin
                        dclk_reg <= 1'b1;
                    end
                end
                U_REQ: begin
                    preq_reg <= (cmd_reg == CMD_PROGRAM);
                    ereq_reg <= (cmd_reg == CMD_ERASE);
                    if (busy_s_reg[1]) begin
                        hold_reg <= 8'h00; st_reg <= U_WAIT;
                    end
                end
                U_WAIT: if (!busy_s_reg[1]) begin
                    preq_reg <= 1'b0; ereq_reg <= 1'b0;
                    dshift_reg <= 1'b0; aclk_reg <= 1'b0; ashift_reg <= 1'b0;
                    o_done <= 1'b1; st_reg <= U_IDLE;
                end
                default: st_reg <= U_IDLE;
            endcase
        end
    end

    assign link.address_shift_clock   = aclk_reg;
    assign link.address_shift_control = ashift_reg;
    assign link.address_serial_in     = adin_reg;
    assign link.data_shift_clock      = dclk_reg;
    assign link.data_shift_control    = dshift_reg;
    assign link.data_serial_in        = ddin_reg;
    assign link.program_req           = preq_reg;
    assign link.erase_req             = ereq_reg;
endmodule
`default_nettype wire

// file: test/user_flash_checker.sv
// concurrent checks on the serial link between user logic and the flash block
`timescale 1ns/100ps
`default_nettype none
module user_flash_checker #(
    parameter int OSC_TICK_CYC = 2,
    parameter int PROG_TICKS   = 16,
    parameter int ERASE_TICKS  = 64
) (
    input  wire logic i_ref_clk,                  // clock
    input  wire logic i_nrst,                     // sync reset, low
    input  wire logic address_shift_control,      // shift or increment
    input  wire logic address_shift_clock,        // address clock
    input  wire logic address_serial_in,          // address bit
    input  wire logic program_req,                // program request
    input  wire logic erase_req,                  // erase request
    input  wire logic busy,                       // operation running
    input  wire logic divided_internal_clock_out  // oscillator over four
);
    localparam int MIN_BUSY = PROG_TICKS * OSC_TICK_CYC;
    localparam int MAX_BUSY = ERASE_TICKS * OSC_TICK_CYC * 4 + 64;
    logic [15:0] busy_cnt_reg;
    logic [15:0] busy_cnt_next;

    // length of the current busy stretch
    assign busy_cnt_next = busy ? busy_cnt_reg + 16'h0001 : 16'h0000;
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            busy_cnt_reg <= 16'h0000;
        end else begin
            busy_cnt_reg <= busy_cnt_next;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    busy_reset_low_a: assert property (disable iff (1'b0) !i_nrst |=> !busy)
        else $error("busy not low after reset edge");
    busy_has_cause_a: assert property ($rose(busy) |-> program_req || erase_req)
        else $error("busy rose without a request");
    busy_rises_fast_a: assert property ($rose(program_req) |-> ##[1:40] busy)
        else $error("busy late after program request");
    erase_busy_fast_a: assert property ($rose(erase_req) |-> ##[1:40] busy)
        else $error("busy late after erase request");
    prog_req_held_a: assert property ($fell(program_req) |-> !busy)
        else $error("program request dropped while busy");
    erase_req_held_a: assert property ($fell(erase_req) |-> !busy)
        else $error("erase request dropped while busy");
    one_req_only_a: assert property (!(program_req && erase_req))
        else $error("program and erase requested together");
    busy_min_len_a: assert property ($fell(busy) |-> busy_cnt_reg >= MIN_BUSY)
        else $error("busy too short for a timed operation");
    busy_max_len_a: assert property (busy |-> busy_cnt_reg < MAX_BUSY)
        else $error("busy stuck high");
    addr_bit_setup_a: assert property ($rose(address_shift_clock) |->
        $stable(address_serial_in) && $stable(address_shift_control))
        else $error("address bit changed at shift clock edge");
    divclk_runs_a: assert property (1'b1 |-> ##[1:16] $changed(divided_internal_clock_out))
        else $error("divided clock not running");
    divclk_half_a: assert property ($changed(divided_internal_clock_out) |=>
        $stable(divided_internal_clock_out)[*3])
        else $error("divided clock half period too short");

    prog_seen_c: cover property ($rose(busy) && program_req);
    erase_seen_c: cover property ($rose(busy) && erase_req);
    stream_seen_c: cover property ($rose(address_shift_clock) && !address_shift_control);
endmodule
`default_nettype wire

// file: test/user_flash_serial_port_bench.sv
// self-checking bench joining user end and flash end over the serial link
`include "user_flash_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module user_flash_serial_port_bench;
    import user_flash_pkg::*;
    localparam int TICK_CYC = 2;
    localparam int PROG_TK  = 4;
    localparam int ERASE_TK = 8;
    localparam int LIMIT    = 5000;
    localparam int CEILING  = 60000;
    logic                  i_ref_clk;
    logic                  i_nrst;
    logic                  i_start;
    logic                  i_next;
    logic                  i_jtag_en;
    logic                  i_jtag_prog;
    flash_cmd_t            i_cmd;
    logic [`UF_ADDR_W-1:0] i_addr;
    logic [`UF_ADDR_W-1:0] i_jtag_addr;
    logic [`UF_DATA_W-1:0] i_wdata;
    logic [`UF_DATA_W-1:0] i_jtag_wdata;
    logic [`UF_DATA_W-1:0] o_jtag_rdata;
    logic [`UF_DATA_W-1:0] o_rdata;
    logic                  o_ready;
    logic                  o_rvalid;
    logic                  o_done;
    logic [`UF_DATA_W-1:0] d1, d2, d3;
    logic [`UF_DATA_W-1:0] exp_q[$];
    logic [31:0]           seed;
    int                    err_total, compares, done_exp, done_seen, cyc;

    user_flash_if user_flash_if_i ();
    user_flash_array #(.OSC_TICK_CYC(TICK_CYC), .PROG_TICKS(PROG_TK), .ERASE_TICKS(ERASE_TK))
        user_flash_array_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .link(user_flash_if_i),
        .i_jtag_en(i_jtag_en), .i_jtag_addr(i_jtag_addr), .i_jtag_wdata(i_jtag_wdata),
        .i_jtag_prog(i_jtag_prog), .o_jtag_rdata(o_jtag_rdata));
    user_flash_user user_flash_user_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
        .link(user_flash_if_i), .i_start(i_start), .i_cmd(i_cmd), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_next(i_next), .o_ready(o_ready), .o_rdata(o_rdata),
        .o_rvalid(o_rvalid), .o_done(o_done));
    user_flash_checker #(.OSC_TICK_CYC(TICK_CYC), .PROG_TICKS(PROG_TK), .ERASE_TICKS(ERASE_TK))
        user_flash_checker_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
        .address_shift_control(user_flash_if_i.address_shift_control),
        .address_shift_clock(user_flash_if_i.address_shift_clock),
        .address_serial_in(user_flash_if_i.address_serial_in),
        .program_req(user_flash_if_i.program_req), .erase_req(user_flash_if_i.erase_req),
        .busy(user_flash_if_i.busy),
        .divided_internal_clock_out(user_flash_if_i.divided_internal_clock_out));

    initial begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction

    task automatic wait_ready();
        int n;
        n = 0;
        @(negedge i_ref_clk);
        while (o_ready !== 1'b1 && n < LIMIT) begin
            @(negedge i_ref_clk);
            n++;
        end
        if (n >= LIMIT) begin
            err_total++;
            $display("wrong value ready expected 1 seen %b", o_ready);
        end
    endtask

    // start held two edges: the second one must be refused while not ready
    task automatic op(input flash_cmd_t c, input logic [8:0] a, input logic [15:0] d);
        wait_ready();
        if (c == CMD_NONE) exp_q.push_back(d);
        else done_exp++;
        @(posedge i_ref_clk);
        i_start <= 1'b1;
        i_cmd   <= c;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        @(posedge i_ref_clk);
        i_start <= 1'b0;
        wait_ready();
    endtask

    task automatic next_word(input logic [15:0] d);
        wait_ready();
        exp_q.push_back(d);
        @(posedge i_ref_clk);
        i_next <= 1'b1;
        @(posedge i_ref_clk);
        i_next <= 1'b0;
        wait_ready();
    endtask

    // result watcher
    always @(posedge i_ref_clk) begin
        if (o_rvalid === 1'b1) begin
            if (exp_q.size() == 0) cmp16("unexpected read", ~o_rdata, o_rdata);
            else cmp16("read word", exp_q.pop_front(), o_rdata);
        end
        if (o_done === 1'b1) done_seen++;
        cyc++;
        if (cyc == CEILING) begin
            err_total++;
            report_and_stop();
        end
    end

    initial begin
        logic [8:0] edges [4];
        edges = '{9'h000, `UF_SEC0_LAST, `UF_SEC1_FIRST, `UF_ADDR_LAST};
        seed = 32'hde85;
        i_nrst <= 1'b0;
        i_start <= 1'b0;
        i_next <= 1'b0;
        i_cmd <= CMD_NONE;
        i_addr <= 9'h000;
        i_wdata <= 16'h0000;
        i_jtag_en <= 1'b0;
        i_jtag_prog <= 1'b0;
        i_jtag_addr <= 9'h000;
        i_jtag_wdata <= 16'h0000;
        repeat (10) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        op(CMD_ERASE, 9'h000, 16'h0000);
        op(CMD_ERASE, 9'h1ff, 16'h0000);
        foreach (edges[k]) op(CMD_NONE, edges[k], `UF_ERASED_WORD);
        d1 = rnd();
        d2 = rnd();
        d3 = rnd();
        op(CMD_PROGRAM, 9'h105, d1);
        op(CMD_PROGRAM, 9'h106, d2);
        op(CMD_PROGRAM, `UF_SEC0_LAST, d2);
        op(CMD_NONE, 9'h105, d1);
        next_word(d2);
        op(CMD_NONE, `UF_SEC0_LAST, d2);
        op(CMD_ERASE, 9'h0ab, 16'h0000);
        op(CMD_NONE, `UF_SEC0_LAST, `UF_ERASED_WORD);
        op(CMD_NONE, 9'h105, d1);
        op(CMD_PROGRAM, 9'h105, d3);
        op(CMD_NONE, 9'h105, d1 & d3);
        @(posedge i_ref_clk);
        i_jtag_en <= 1'b1;
        i_jtag_addr <= 9'h106;
        repeat (3) @(posedge i_ref_clk);
        cmp16("jtag read", d2, o_jtag_rdata);
        i_jtag_wdata <= d3;
        i_jtag_prog <= 1'b1;
        @(posedge i_ref_clk);
        i_jtag_prog <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        cmp16("jtag read after program", d2 & d3, o_jtag_rdata);
        i_jtag_en <= 1'b0;
        op(CMD_NONE, 9'h106, d2 & d3);
        repeat (4) @(posedge i_ref_clk);
        cmp16("done pulses", done_exp[15:0], done_seen[15:0]);
        cmp16("reads left", 16'h0000, 16'(exp_q.size()));
        report_and_stop();
    end
endmodule
`default_nettype wire
